// ==== hw/pcsr_pkg.sv ====
package pcsr_pkg;

	// ----------------------------------------
	// Widths and lanes
	// ----------------------------------------
	localparam int AD_W     = 32;
	localparam int BYTE_W   = 8;
	localparam int LANES    = AD_W / BYTE_W;
	localparam int LSB_LANE = 0;
	localparam int MSB_LANE = LANES - 1;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ      = 20_000_000;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [AD_W-1:0] AD_RST   = 32'h0000_0000;
	localparam logic            OE_RST   = 1'h0;
	localparam logic            PIN_IDLE = 1'h1;

	// ----------------------------------------
	// Bus sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_DATA,
		SEQ_TURN
	} pcsr_seq_e;

endpackage

// ==== hw/pcsr_smp_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface pcsr_smp_if;
	logic        rst_n_sync;
	logic        frame_n;
	logic        irdy_n;
	logic        trdy_n;
	logic        use_bus_clk;
	logic [31:0] ad;

	modport src
	(
		output rst_n_sync,
		output frame_n,
		output irdy_n,
		output trdy_n,
		output use_bus_clk,
		output ad
	);

	modport dst
	(
		input rst_n_sync,
		input frame_n,
		input irdy_n,
		input trdy_n,
		input use_bus_clk,
		input ad
	);
endinterface

`default_nettype wire

// ==== hw/pcsr_sampler.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcsr_sampler
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Raw pins
	input  wire logic        frame_n_in,
	input  wire logic        irdy_n_in,
	input  wire logic        trdy_n_in,
	input  wire logic        use_bus_clk_in,
	input  wire logic [31:0] ad_in,
	// Sampled side
	pcsr_smp_if.src          smp
);

	localparam int PW = 4 + pcsr_pkg::AD_W;

	logic [PW-1:0] meta_r;
	logic [PW-1:0] meta_nxt;
	logic [PW-1:0] hold_r;
	logic [PW-1:0] hold_nxt;
	logic          rst_meta_r;
	logic          rst_hold_r;

	// ----------------------------------------
	// Reset: async assert, release on clock
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_r <= 1'h0;
			rst_hold_r <= 1'h0;
		end
		else
		begin
			rst_meta_r <= 1'h1;
			rst_hold_r <= rst_meta_r;
		end
	end

	// ----------------------------------------
	// Pin sampling, rising edge only
	// ----------------------------------------
	always_comb
	begin
		meta_nxt = {frame_n_in, irdy_n_in, trdy_n_in, use_bus_clk_in, ad_in};
		hold_nxt = meta_r;
	end

	// Idle pins read as deasserted so no phase is seen during reset
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_r <= {{3{pcsr_pkg::PIN_IDLE}}, 1'h0, pcsr_pkg::AD_RST};
			hold_r <= {{3{pcsr_pkg::PIN_IDLE}}, 1'h0, pcsr_pkg::AD_RST};
		end
		else
		begin
			meta_r <= meta_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign smp.rst_n_sync  = rst_hold_r;
	assign smp.frame_n     = hold_r[PW-1];
	assign smp.irdy_n      = hold_r[PW-2];
	assign smp.trdy_n      = hold_r[PW-3];
	assign smp.use_bus_clk = hold_r[PW-4];
	assign smp.ad          = hold_r[pcsr_pkg::AD_W-1:0];

endmodule

`default_nettype wire

// ==== hw/pcsr_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcsr_top
#(
	parameter int AD_W = pcsr_pkg::AD_W
)
(
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            reset_n,
	// Bus pins
	input  wire logic            frame_n_in,
	input  wire logic            irdy_n_in,
	input  wire logic            trdy_n_in,
	input  wire logic [AD_W-1:0] ad_in,
	output var  logic [AD_W-1:0] ad_out,
	output var  logic            ad_oe,
	// Core clock strap
	input  wire logic            use_bus_clk,
	output var  logic            core_on_bus_clk,
	output var  logic            fast_rate_ok,
	// Internal side
	input  wire logic            target_read,
	input  wire logic [AD_W-1:0] rd_data,
	output var  logic [AD_W-1:0] addr,
	output var  logic            addr_valid,
	output var  logic [AD_W-1:0] wr_data,
	output var  logic            wr_valid,
	output var  logic            rd_taken,
	output var  logic [7:0]      wr_lsb,
	output var  logic [7:0]      wr_msb,
	output var  logic            busy
);

	// Lane map and sampler are fixed at 32 bits
	if (AD_W != pcsr_pkg::AD_W)
	begin
		$error("pcsr_top: only a 32-bit address/data path is supported");
	end

	// ----------------------------------------
	// Lane pick, used for both end bytes
	// ----------------------------------------
	function automatic logic [7:0] lane(input logic [AD_W-1:0] w, input int idx);
		lane = w[idx*pcsr_pkg::BYTE_W +: pcsr_pkg::BYTE_W];
	endfunction

	pcsr_smp_if smp ();

	pcsr_sampler u_smp
	(
		.sys_clk        (sys_clk),
		.reset_n        (reset_n),
		.frame_n_in     (frame_n_in),
		.irdy_n_in      (irdy_n_in),
		.trdy_n_in      (trdy_n_in),
		.use_bus_clk_in (use_bus_clk),
		.ad_in          (ad_in),
		.smp            (smp)
	);

	wire logic rst_n = smp.rst_n_sync;

	// ----------------------------------------
	// Bus sequencer
	// ----------------------------------------
	pcsr_pkg::pcsr_seq_e seq_r;
	pcsr_pkg::pcsr_seq_e seq_nxt;
	logic            rd_r;
	logic            rd_nxt;
	logic            oe_r;
	logic            oe_nxt;
	logic [AD_W-1:0] dout_r;
	logic [AD_W-1:0] dout_nxt;
	logic [AD_W-1:0] addr_r;
	logic [AD_W-1:0] addr_nxt;
	logic [AD_W-1:0] wdat_r;
	logic [AD_W-1:0] wdat_nxt;
	logic            av_r;
	logic            av_nxt;
	logic            wv_r;
	logic            wv_nxt;
	logic            rt_r;
	logic            rt_nxt;
	logic            busy_r;
	logic            busy_nxt;
	logic            done;
	logic            frame_act;

	always_comb
	begin
		frame_act = !smp.frame_n;
		done      = !smp.irdy_n && !smp.trdy_n;
		seq_nxt   = seq_r;
		rd_nxt    = rd_r;
		oe_nxt    = oe_r;
		dout_nxt  = dout_r;
		addr_nxt  = addr_r;
		wdat_nxt  = wdat_r;
		av_nxt    = 1'h0;
		wv_nxt    = 1'h0;
		rt_nxt    = 1'h0;
		unique case (seq_r)
			pcsr_pkg::SEQ_IDLE:
			begin
				oe_nxt = 1'h0;
				if (frame_act)
				begin
					addr_nxt = smp.ad;
					av_nxt   = 1'h1;
					rd_nxt   = target_read;
					seq_nxt  = pcsr_pkg::SEQ_DATA;
				end
			end
			pcsr_pkg::SEQ_DATA:
			begin
				// Drive only once the address owner has let go
				oe_nxt   = rd_r;
				dout_nxt = rd_data;
				if (done)
				begin
					if (rd_r)
						rt_nxt = 1'h1;
					else
					begin
						wdat_nxt = smp.ad;
						wv_nxt   = 1'h1;
					end
					if (!frame_act)
					begin
						oe_nxt  = 1'h0;
						seq_nxt = pcsr_pkg::SEQ_TURN;
					end
				end
			end
			pcsr_pkg::SEQ_TURN:
			begin
				// One idle clock so two drivers never overlap
				oe_nxt  = 1'h0;
				seq_nxt = pcsr_pkg::SEQ_IDLE;
			end
		endcase
		// Registered so the output pin comes from a flop
		busy_nxt = seq_nxt != pcsr_pkg::SEQ_IDLE;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq_r  <= pcsr_pkg::SEQ_IDLE;
			rd_r   <= 1'h0;
			oe_r   <= pcsr_pkg::OE_RST;
			dout_r <= pcsr_pkg::AD_RST;
			addr_r <= pcsr_pkg::AD_RST;
			wdat_r <= pcsr_pkg::AD_RST;
			av_r   <= 1'h0;
			wv_r   <= 1'h0;
			rt_r   <= 1'h0;
			busy_r <= 1'h0;
		end
		else
		begin
			seq_r  <= seq_nxt;
			rd_r   <= rd_nxt;
			oe_r   <= oe_nxt;
			dout_r <= dout_nxt;
			addr_r <= addr_nxt;
			wdat_r <= wdat_nxt;
			av_r   <= av_nxt;
			wv_r   <= wv_nxt;
			rt_r   <= rt_nxt;
			busy_r <= busy_nxt;
		end
	end

	// ----------------------------------------
	// Byte lanes and core clock source
	// ----------------------------------------
	logic [7:0] lsb_r;
	logic [7:0] lsb_nxt;
	logic [7:0] msb_r;
	logic [7:0] msb_nxt;
	logic       cob_r;
	logic       cob_nxt;
	logic       fr_r;
	logic       fr_nxt;

	always_comb
	begin
		lsb_nxt = lsb_r;
		msb_nxt = msb_r;
		if (seq_r == pcsr_pkg::SEQ_DATA && done && !rd_r)
		begin
			lsb_nxt = lane(smp.ad, pcsr_pkg::LSB_LANE);
			msb_nxt = lane(smp.ad, pcsr_pkg::MSB_LANE);
		end
		// Strap sampled only while idle: no switch mid transfer
		cob_nxt = (seq_r == pcsr_pkg::SEQ_IDLE) ? smp.use_bus_clk : cob_r;
		fr_nxt  = !cob_nxt;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lsb_r <= 8'h00;
			msb_r <= 8'h00;
			cob_r <= 1'h0;
			fr_r  <= 1'h1;
		end
		else
		begin
			lsb_r <= lsb_nxt;
			msb_r <= msb_nxt;
			cob_r <= cob_nxt;
			fr_r  <= fr_nxt;
		end
	end

	assign ad_out          = dout_r;
	assign ad_oe           = oe_r;
	assign addr            = addr_r;
	assign addr_valid      = av_r;
	assign wr_data         = wdat_r;
	assign wr_valid        = wv_r;
	assign rd_taken        = rt_r;
	assign wr_lsb          = lsb_r;
	assign wr_msb          = msb_r;
	assign core_on_bus_clk = cob_r;
	assign fast_rate_ok    = fr_r;
	assign busy            = busy_r;

endmodule

`default_nettype wire

// ==== verification/pcsr_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcsr_checker
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	// Bus pins
	input wire logic        frame_n_in,
	input wire logic        irdy_n_in,
	input wire logic        trdy_n_in,
	input wire logic [31:0] ad_in,
	input wire logic        ad_oe,
	// Internal side
	input wire logic        core_on_bus_clk,
	input wire logic        fast_rate_ok,
	input wire logic [31:0] addr,
	input wire logic        addr_valid,
	input wire logic [31:0] wr_data,
	input wire logic        wr_valid,
	input wire logic        rd_taken,
	input wire logic [7:0]  wr_lsb,
	input wire logic [7:0]  wr_msb,
	input wire logic        busy
);
	// ----------------
	// Port relations
	// ----------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	AST_RST_FLOAT: assert property ($rose(reset_n) |-> !ad_oe && !busy)
		else $error("bus driven at reset exit");
	AST_RST_SYNC: assert property ($rose(reset_n) |=> !busy && !addr_valid)
		else $error("left reset too early");
	AST_ADDR: assert property (addr_valid |-> addr == $past(ad_in, 3) && !$past(frame_n_in, 3))
		else $error("bad address capture");
	AST_WR: assert property (wr_valid |-> wr_data == $past(ad_in, 3) && !$past(irdy_n_in, 3))
		else $error("bad write capture");
	AST_WR_TRDY: assert property (wr_valid |-> !$past(trdy_n_in, 3))
		else $error("write without target ready");
	AST_LANES: assert property (wr_valid |-> wr_lsb == wr_data[7:0] && wr_msb == wr_data[31:24])
		else $error("byte lanes swapped");
	AST_RD: assert property (rd_taken |-> !$past(irdy_n_in, 3) && !$past(trdy_n_in, 3) && !wr_valid)
		else $error("read phase miscounted");
	AST_ONE_ADDR: assert property (addr_valid |=> !addr_valid [*2])
		else $error("address phase repeated");
	AST_OWNER: assert property (ad_oe |-> busy && !wr_valid)
		else $error("driving outside a read");
	AST_FAST: assert property (fast_rate_ok != core_on_bus_clk)
		else $error("fast rate with bus clock");
	cover property (wr_valid);
	cover property (rd_taken);
	cover property (core_on_bus_clk);
endmodule
bind pcsr_top pcsr_checker chk_u (.sys_clk, .reset_n, .frame_n_in, .irdy_n_in, .trdy_n_in,
	.ad_in, .ad_oe, .core_on_bus_clk, .fast_rate_ok, .addr, .addr_valid, .wr_data,
	.wr_valid, .rd_taken, .wr_lsb, .wr_msb, .busy);
`default_nettype wire

// ==== verification/pcsr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcsr_host
(
	// Clock
	input  wire logic        sys_clk,
	// Master pins
	output var  logic        frame_n,
	output var  logic        irdy_n,
	output var  logic        trdy_n,
	output var  logic [31:0] ad
);
	// ----------------
	// Bus master
	// ----------------
	initial
	begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		trdy_n = 1'b1;
		ad = 32'h0;
	end
	task automatic phase(input logic f, input logic r, input logic [31:0] v);
		@(posedge sys_clk);
		frame_n <= f;
		irdy_n <= r;
		trdy_n <= r;
		ad <= v;
	endtask
	// Released lines carry a moving pattern, never the last value
	task automatic burst(input logic rd, input logic [31:0] a, input int n, input logic slow);
		phase(1'b0, 1'b1, a);
		for (int k = 0; k < n; k++)
		begin
			if (slow)
				phase(1'b0, 1'b1, ~a);
			phase(k == n - 1, 1'b0, rd ? ~(a + k) : a + k);
		end
		phase(1'b1, 1'b1, ~(a + n));
	endtask
endmodule
`default_nettype wire

// ==== verification/test_pci_system_clock_reset_ad.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_pci_system_clock_reset_ad;
	logic        sys_clk, reset_n, use_bus_clk, target_read, frame_n, irdy_n, trdy_n;
	logic        ad_oe, busy, addr_valid, wr_valid, rd_taken, core_on_bus_clk, fast_rate_ok;
	logic [31:0] host_ad, ad_w, ad_out, rd_data, addr, wr_data;
	logic [7:0]  wr_lsb, wr_msb;
	int          bad_count, n_compared, cyc, n_wr, n_rd, n_ad, n_out;
	// ----------------
	// Wiring and monitor
	// ----------------
	assign ad_w = ad_oe ? ad_out : host_ad;
	pcsr_host host_u (.sys_clk, .frame_n, .irdy_n, .trdy_n, .ad(host_ad));
	pcsr_top dut_u (.sys_clk, .reset_n, .frame_n_in(frame_n), .irdy_n_in(irdy_n),
		.trdy_n_in(trdy_n), .ad_in(ad_w), .ad_out, .ad_oe, .use_bus_clk, .core_on_bus_clk,
		.fast_rate_ok, .target_read, .rd_data, .addr, .addr_valid, .wr_data, .wr_valid,
		.rd_taken, .wr_lsb, .wr_msb, .busy);
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (wr_valid === 1'b1) n_wr++;
		if (rd_taken === 1'b1) n_rd++;
		if (addr_valid === 1'b1) n_ad++;
		if (ad_oe === 1'b1 && ad_out === rd_data) n_out++;
		if (cyc == 4000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle;
		repeat (4) @(negedge sys_clk);
		for (int i = 0; i < 40 && busy !== 1'b0; i++)
			@(negedge sys_clk);
	endtask
	task automatic t_write(input logic [31:0] a, input int n, input logic slow);
		int          a0, w0;
		logic [31:0] e;
		a0 = n_ad;
		w0 = n_wr;
		e = a + n - 1;
		host_u.burst(1'b0, a, n, slow);
		idle();
		chk(n_ad - a0, 1);
		chk(n_wr - w0, n);
		chk(addr, a);
		chk(wr_data, e);
		chk(wr_lsb, e[7:0]);
		chk(wr_msb, e[31:24]);
		$display("write test done");
	endtask
	task automatic t_read;
		int r0, o0, w0;
		r0 = n_rd;
		o0 = n_out;
		w0 = n_wr;
		@(posedge sys_clk);
		target_read <= 1'b1;
		rd_data <= 32'h5a3c_96e1;
		host_u.burst(1'b1, 32'h0000_1000, 3, 1'b0);
		idle();
		chk(n_rd - r0, 3);
		chk(n_out > o0, 1);
		chk(ad_out, 32'h5a3c_96e1);
		chk(n_wr - w0, 0);
		chk(ad_oe, 0);
		$display("read test done");
	endtask
	task automatic t_strap;
		@(posedge sys_clk);
		use_bus_clk <= 1'b1;
		repeat (6) @(negedge sys_clk);
		chk(core_on_bus_clk, 1);
		chk(fast_rate_ok, 0);
		@(posedge sys_clk);
		use_bus_clk <= 1'b0;
		repeat (6) @(negedge sys_clk);
		chk(core_on_bus_clk, 0);
		chk(fast_rate_ok, 1);
		$display("strap test done");
	endtask
	task automatic t_midreset;
		fork
			host_u.burst(1'b1, 32'h0000_2000, 8, 1'b0);
		join_none
		for (int i = 0; i < 20 && ad_oe !== 1'b1; i++)
			@(negedge sys_clk);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		#1;
		chk(ad_oe, 0);
		chk(busy, 0);
		chk(addr, 0);
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(busy, 0);
		idle();
		$display("reset test done");
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		reset_n = 1'b0;
		use_bus_clk = 1'b0;
		target_read = 1'b0;
		rd_data = 32'h0;
		repeat (16) @(posedge sys_clk);
		chk(fast_rate_ok, 1);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_write(32'h8040_2010, 1, 1'b0);
		t_write(32'hfedc_ba98, 4, 1'b1);
		t_read();
		t_strap();
		t_midreset();
		@(posedge sys_clk);
		target_read <= 1'b0;
		t_write(32'h0102_0304, 2, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
